// *** design/shelf_life_calculator.sv ***
// remaining-life arithmetic core with apb registers and expiry interrupt
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] start seeds accumulator, clears error counters
// [RULE_02] difference is measurement minus initial temperature
// [RULE_03] index is difference shifted right two
// [RULE_04] difference above 236: high error, index 59
// [RULE_05] initial above measurement: low error, index 0
// [RULE_06] subtract entries zero through index, keep last
// [RULE_07] interpolate for index 1..58, bump decrement
// [RULE_08] bit one subtracts half bumped decrement
// [RULE_09] bit zero subtracts quarter bumped decrement
// [RULE_10] sixty byte decrement table, host writable
// [RULE_11] run only when enabled, armed by start
// [RULE_12] flag and interrupt when life reaches zero
// [RULE_13] zero-extend subtrahends, two's complement arithmetic
module shelf_life_calculator (
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        START,
    input  wire logic        EVENT,
    input  wire logic [9:0]  MEAS,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             BUSY,
    output logic             EXPIRED,
    output logic             IRQ
);
    typedef enum logic [1:0] {IDLE, WALK, FINISH} state_t;

    function automatic logic [21:0] widen(input logic [7:0] v);
        widen = {14'h0000, v};                                    // [RULE_13]
    endfunction

    logic [7:0]  table_reg [0:59];
    state_t      state_reg;
    logic [21:0] acc_reg;
    logic [7:0]  lo_reg;
    logic [7:0]  hi_reg;
    logic [7:0]  index_reg;
    logic [7:0]  count_reg;
    logic [7:0]  dec_reg;
    logic [9:0]  diff_reg;
    logic [1:0]  ctrl_reg;
    logic [15:0] init_reg;
    logic [9:0]  tinit_reg;
    logic [3:0]  stat_reg;
    logic [3:0]  mask_reg;
    logic        armed_reg;
    logic [21:0] fraction;
    logic [9:0]  diff_next;
    logic [7:0]  index_next;
    logic        wr;
    logic        rd_hit;
    logic        tbl_hit;
    logic [5:0]  tbl_idx;
    logic [3:0]  ev_set;
    logic [21:0] acc_next;

    // ==========================================================
    // apb decode: zero wait states, unmapped reads zero with error
    assign PREADY  = 1'b1;
    assign wr      = PSEL & PENABLE & PWRITE;
    assign tbl_idx = PADDR[7:2];
    assign tbl_hit = (PADDR[11:8] == life_pkg::TABLE_OFF[11:8])
                     && (PADDR[7:2] < 6'(life_pkg::TABLE_LEN))
                     && (PADDR[1:0] == 2'b00);
    assign rd_hit  = tbl_hit || (PADDR == life_pkg::CTRL_OFF) || (PADDR == life_pkg::INIT_OFF)
                     || (PADDR == life_pkg::TINIT_OFF) || (PADDR == life_pkg::LIFE_OFF)
                     || (PADDR == life_pkg::ERR_OFF) || (PADDR == life_pkg::STAT_OFF)
                     || (PADDR == life_pkg::MASK_OFF);
    assign PSLVERR = PSEL & PENABLE & ~rd_hit;

    // read mux straight from the register flops, no added latency
    always_comb begin
        PRDATA = 32'h0000_0000;
        if (PSEL && !PWRITE) begin
            if (tbl_hit) PRDATA = {24'h000000, table_reg[tbl_idx]};
            else case (PADDR)
                life_pkg::CTRL_OFF:  PRDATA = {30'h0, ctrl_reg};
                life_pkg::INIT_OFF:  PRDATA = {16'h0000, init_reg};
                life_pkg::TINIT_OFF: PRDATA = {22'h0, tinit_reg};
                life_pkg::LIFE_OFF:  PRDATA = {10'h0, acc_reg};
                life_pkg::ERR_OFF:   PRDATA = {16'h0000, hi_reg, lo_reg};
                life_pkg::STAT_OFF:  PRDATA = {28'h0, stat_reg};
                life_pkg::MASK_OFF:  PRDATA = {28'h0, mask_reg};
                default:             PRDATA = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_reg  <= 2'b00;
            init_reg  <= 16'h0000;
            tinit_reg <= 10'h000;
            mask_reg  <= 4'h0;
        end else if (wr) begin
            if (PADDR == life_pkg::CTRL_OFF)  ctrl_reg  <= PWDATA[1:0];
            if (PADDR == life_pkg::INIT_OFF)  init_reg  <= PWDATA[15:0];
            if (PADDR == life_pkg::TINIT_OFF) tinit_reg <= PWDATA[9:0];
            if (PADDR == life_pkg::MASK_OFF)  mask_reg  <= PWDATA[3:0];
        end
    end

    // decrement table; no reset so it maps to plain memory
    always_ff @(posedge SYS_CLK) begin
        if (wr && tbl_hit) begin
            table_reg[tbl_idx] <= PWDATA[7:0];                     // [RULE_10]
        end
    end

    // ==========================================================
    // event front end
    always_comb begin
        diff_next  = MEAS - tinit_reg;                             // [RULE_02]
        index_next = diff_next[9:life_pkg::INDEX_SHIFT];           // [RULE_03]
        if (diff_next > life_pkg::DIFF_HIGH) begin
            index_next = life_pkg::INDEX_TOP;                      // [RULE_04]
        end
        if (tinit_reg > MEAS) begin
            index_next = life_pkg::INDEX_ZERO;                     // [RULE_05]
        end
    end

    // arm on start when enabled; events ignored before that
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) armed_reg <= 1'b0;
        else if (START) armed_reg <= ctrl_reg[0];                  // [RULE_11]
    end

    // ==========================================================
    // sequencer: one table entry per cycle
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= IDLE;
            index_reg <= 8'h00;
            count_reg <= 8'h00;
            diff_reg  <= 10'h000;
        end else begin
            case (state_reg)
                IDLE: begin
                    if (EVENT && armed_reg && ctrl_reg[0] && !START) begin // [RULE_11]
                        diff_reg  <= diff_next;
                        index_reg <= index_next;
                        count_reg <= 8'h00;
                        state_reg <= WALK;
                    end
                end
                WALK: begin
                    count_reg <= count_reg + 8'h01;
                    if (count_reg == index_reg) state_reg <= FINISH;   // [RULE_06]
                end
                FINISH: state_reg <= IDLE;
                default: state_reg <= IDLE;
            endcase
        end
    end

    life_step u_step (
        .diff     (diff_reg),
        .index    (index_reg),
        .last_dec (dec_reg),
        .fraction (fraction)
    );

    // accumulator next value
    always_comb begin
        acc_next = acc_reg;
        if (state_reg == WALK) acc_next = acc_reg - widen(table_reg[count_reg[5:0]]); // [RULE_06]
        else if (state_reg == FINISH) acc_next = acc_reg - fraction;  // [RULE_08] [RULE_09]
    end

    // ==========================================================
    // accumulator, decrement and error counters
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            acc_reg <= 22'h000000;
            dec_reg <= 8'h00;
            lo_reg  <= 8'h00;
            hi_reg  <= 8'h00;
        end else if (START) begin
            acc_reg <= {init_reg, 6'h00};                          // [RULE_01]
            lo_reg  <= 8'h00;                                      // [RULE_01]
            hi_reg  <= 8'h00;
        end else begin
            acc_reg <= acc_next;
            if (state_reg == WALK) dec_reg <= table_reg[count_reg[5:0]]; // [RULE_06]
            if (state_reg == IDLE && EVENT && armed_reg && ctrl_reg[0]) begin
                if (diff_next > life_pkg::DIFF_HIGH) hi_reg <= hi_reg + 8'h01; // [RULE_04]
                if (tinit_reg > MEAS) lo_reg <= lo_reg + 8'h01;    // [RULE_05]
            end
        end
    end

    // ==========================================================
    // sticky events: set wins over write-one-clear
    assign ev_set[0] = (state_reg == FINISH);
    assign ev_set[1] = (state_reg == IDLE) && EVENT && armed_reg && ctrl_reg[0] && !START
                       && (tinit_reg > MEAS);
    assign ev_set[2] = (state_reg == IDLE) && EVENT && armed_reg && ctrl_reg[0] && !START
                       && (diff_next > life_pkg::DIFF_HIGH);
    assign ev_set[3] = (state_reg == FINISH) && ($signed(acc_next) <= 0);   // [RULE_12]

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) stat_reg <= 4'h0;
        else stat_reg <= (stat_reg & ~((wr && PADDR == life_pkg::STAT_OFF) ? PWDATA[3:0] : 4'h0))
                         | ev_set;
    end

    // expiry pin flags remaining life at or below zero when its enable is set and the core is armed
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) EXPIRED <= 1'b0;
        else EXPIRED <= ctrl_reg[1] && armed_reg && ($signed(acc_next) <= 0); // [RULE_12]
    end

    assign IRQ  = |(stat_reg & mask_reg);
    assign BUSY = (state_reg != IDLE);

    // ==========================================================
    // checks
    property p_seed;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        START |=> (acc_reg == {$past(init_reg), 6'h00}) && lo_reg == 8'h00 && hi_reg == 8'h00;
    endproperty
    a_seed: assert property (p_seed) else $error("seed wrong"); // [RULE_01]

    property p_walk_len;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == IDLE && EVENT && armed_reg && ctrl_reg[0] && !START && index_next == 8'h00)
        |=> state_reg == WALK ##1 state_reg == FINISH;
    endproperty
    a_walk_len: assert property (p_walk_len) else $error("walk length wrong"); // [RULE_06]

    property p_walk_bound;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        state_reg == WALK |-> count_reg <= index_reg;
    endproperty
    a_walk_bound: assert property (p_walk_bound) else $error("walk count past index"); // [RULE_06]

    property p_walk_end;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        state_reg == WALK |-> ##[1:61] state_reg == FINISH;
    endproperty
    a_walk_end: assert property (p_walk_end) else $error("walk overran"); // [RULE_06]

    property p_high;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == IDLE && EVENT && armed_reg && ctrl_reg[0] && !START
         && diff_next > life_pkg::DIFF_HIGH && !(tinit_reg > MEAS))
        |=> index_reg == life_pkg::INDEX_TOP && hi_reg == $past(hi_reg) + 8'h01;
    endproperty
    a_high: assert property (p_high) else $error("high range wrong"); // [RULE_04]

    property p_low;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == IDLE && EVENT && armed_reg && ctrl_reg[0] && !START && tinit_reg > MEAS)
        |=> index_reg == 8'h00 && lo_reg == $past(lo_reg) + 8'h01;
    endproperty
    a_low: assert property (p_low) else $error("low range wrong"); // [RULE_05]

    property p_index;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == IDLE && EVENT && armed_reg && ctrl_reg[0] && !START
         && !(tinit_reg > MEAS) && !(diff_next > life_pkg::DIFF_HIGH))
        |=> index_reg == diff_reg[9:2] && diff_reg == 10'($past(MEAS) - $past(tinit_reg));
    endproperty
    a_index: assert property (p_index) else $error("index wrong"); // [RULE_03]

    property p_no_interp;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == FINISH && !START
         && (index_reg == life_pkg::INDEX_ZERO || index_reg >= life_pkg::INDEX_TOP))
        |=> acc_reg == $past(acc_reg);
    endproperty
    a_no_interp: assert property (p_no_interp) else $error("interpolation not gated"); // [RULE_07]

    property p_frac;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg == FINISH && !START && index_reg == 8'h01 && diff_reg[1:0] == 2'b11)
        |=> acc_reg == $past(acc_reg) - {13'h0000, ({1'b0, $past(dec_reg)} + 9'h001) >> 1}
            - {13'h0000, ({1'b0, $past(dec_reg)} + 9'h001) >> 2};
    endproperty
    a_frac: assert property (p_frac) else $error("fraction wrong"); // [RULE_08] [RULE_09]

    property p_disabled;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (!armed_reg && state_reg == IDLE) |=> state_reg == IDLE;
    endproperty
    a_disabled: assert property (p_disabled) else $error("ran while disarmed"); // [RULE_11]

    property p_irq;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        ev_set[3] |=> stat_reg[3];
    endproperty
    a_irq: assert property (p_irq) else $error("expiry lost"); // [RULE_12]

    // start arms from the enable flag and always beats a same-cycle event
    property p_start_arm;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (START && ctrl_reg[0]) |=> armed_reg;
    endproperty
    a_start_arm: assert property (p_start_arm) else $error("start did not arm"); // [RULE_11]

    property p_start_disarm;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (START && !ctrl_reg[0]) |=> !armed_reg;
    endproperty
    a_start_disarm: assert property (p_start_disarm) else $error("armed while off"); // [RULE_11]

    property p_start_wins;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (START && state_reg == IDLE) |=> state_reg == IDLE;
    endproperty
    a_start_wins: assert property (p_start_wins) else $error("event beat start"); // [RULE_11]

    // counters move only at the accepted event or when start clears them
    property p_counter_hold;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (state_reg != IDLE && !START) |=> hi_reg == $past(hi_reg) && lo_reg == $past(lo_reg);
    endproperty
    a_counter_hold: assert property (p_counter_hold) else $error("counter moved"); // [RULE_04] [RULE_05]

    // expiry pin stays quiet while its enable is off
    property p_expired_pin;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        !ctrl_reg[1] |=> !EXPIRED;
    endproperty
    a_expired_pin: assert property (p_expired_pin) else $error("pin not gated"); // [RULE_12]

    property p_irq_mask;
        @(posedge SYS_CLK) disable iff (!ARST_N)
        (mask_reg == 4'h0) |-> !IRQ;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq not masked"); // [RULE_12]

    c_event: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) state_reg == FINISH);
    c_high:  cover property (@(posedge SYS_CLK) disable iff (!ARST_N) ev_set[2]);
    c_low:   cover property (@(posedge SYS_CLK) disable iff (!ARST_N) ev_set[1]);
    c_exp:   cover property (@(posedge SYS_CLK) disable iff (!ARST_N) ev_set[3]);
    c_frac:  cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
                             state_reg == FINISH && fraction != 22'h000000);
endmodule

// *** design/life_pkg.sv ***
// constants shared by the remaining-life arithmetic core
package life_pkg;
    // ==========================================================
    // widths
    localparam int ACC_W      = 22;
    localparam int TEMP_W     = 10;
    localparam int INDEX_W    = 8;
    localparam int ENTRY_W    = 8;
    localparam int INIT_W     = 16;
    localparam int TABLE_LEN  = 60;
    localparam int TADDR_W    = 6;
    // ==========================================================
    // arithmetic constants
    localparam int              SEED_SHIFT  = 6;
    localparam int              INDEX_SHIFT = 2;
    localparam logic [9:0]      DIFF_HIGH   = 10'h0ec;   // 236
    localparam logic [7:0]      INDEX_TOP   = 8'h3b;     // 59
    localparam logic [7:0]      INDEX_ZERO  = 8'h00;
    localparam int              HALF_BIT    = 1;
    localparam int              QUART_BIT   = 0;
    // ==========================================================
    // register map (apb byte addresses)
    localparam logic [11:0] CTRL_OFF    = 12'h000;  // [0] enable, [1] expiry pin enable
    localparam logic [11:0] INIT_OFF    = 12'h004;  // [15:0] initial life
    localparam logic [11:0] TINIT_OFF   = 12'h008;  // [9:0] initial temperature
    localparam logic [11:0] LIFE_OFF    = 12'h00c;  // [21:0] remaining life, read only
    localparam logic [11:0] ERR_OFF     = 12'h010;  // [7:0] low, [15:8] high error count
    localparam logic [11:0] STAT_OFF    = 12'h014;  // sticky events, write one clears
    localparam logic [11:0] MASK_OFF    = 12'h018;  // interrupt mask
    localparam logic [11:0] TABLE_OFF   = 12'h100;  // 60 words, entry in [7:0]
    localparam int          STAT_W      = 4;        // [0] done [1] low [2] high [3] expired
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
endpackage

// *** design/life_step.sv ***
// combinational interpolation tail of one logging event
`timescale 1ns/1ps
module life_step (
    input  wire logic [9:0]  diff,
    input  wire logic [7:0]  index,
    input  wire logic [7:0]  last_dec,
    output logic      [21:0] fraction
);
    logic [8:0] bumped;
    // ==========================================================
    // fraction subtracted after the table walk
    always_comb begin
        bumped   = {1'b0, last_dec} + 9'h001;                     // [RULE_07]
        fraction = 22'h000000;
        if ((index != life_pkg::INDEX_ZERO) && (index < life_pkg::INDEX_TOP)) begin // [RULE_07]
            if (diff[life_pkg::HALF_BIT]) begin
                fraction = fraction + {14'h0000, bumped[8:1]};    // [RULE_08] [RULE_13]
            end
            if (diff[life_pkg::QUART_BIT]) begin
                fraction = fraction + {15'h0000, bumped[8:2]};    // [RULE_09] [RULE_13]
            end
        end
    end
endmodule

// *** sim/shelf_life_calculator_test.sv ***
// self-checking bench for the remaining-life arithmetic core
`timescale 1ns/1ps
module shelf_life_calculator_test;
    // ==========================================================
    // design ports, inputs driven from time zero
    logic               SYS_CLK = 1'b0;
    logic               ARST_N  = 1'b0;
    logic               START   = 1'b0;
    logic               EVENT   = 1'b0;
    logic        [9:0]  MEAS    = 10'h000;
    logic               PSEL    = 1'b0;
    logic               PENABLE = 1'b0;
    logic               PWRITE  = 1'b0;
    logic        [11:0] PADDR   = 12'h000;
    logic        [31:0] PWDATA  = 32'h0000_0000;
    logic        [31:0] PRDATA;
    logic               PREADY;
    logic               PSLVERR;
    logic               BUSY;
    logic               EXPIRED;
    logic               IRQ;
    // ==========================================================
    // reference state kept by the bench
    logic        [7:0]  tab [60];
    logic        [9:0]  tinit;
    logic signed [21:0] exp_life;
    logic        [7:0]  exp_lo;
    logic        [7:0]  exp_hi;
    logic        [3:0]  exp_stat;
    logic        [31:0] rd;
    logic               er;
    logic        [9:0]  meas_list [8];
    int                 n_mismatch  = 0;
    int                 checks_done = 0;

    // 25 MHz system clock
    always #20 SYS_CLK = ~SYS_CLK;

    shelf_life_calculator dut_u (
        .SYS_CLK (SYS_CLK), .ARST_N (ARST_N), .START (START), .EVENT (EVENT),
        .MEAS (MEAS), .PSEL (PSEL), .PENABLE (PENABLE), .PWRITE (PWRITE),
        .PADDR (PADDR), .PWDATA (PWDATA), .PRDATA (PRDATA), .PREADY (PREADY),
        .PSLVERR (PSLVERR), .BUSY (BUSY), .EXPIRED (EXPIRED), .IRQ (IRQ)
    );

    // ==========================================================
    // verdict, reached from the main sequence and from any timeout
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ==========================================================
    // apb master: request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 50) begin
            check("apb_ready_timeout", 32'h1, 32'h0);
            results();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    // start-of-logging strobe, optionally with an event in the same cycle
    task automatic start_log(input logic [15:0] init, input logic with_ev);
        @(posedge SYS_CLK);
        START <= 1'b1;
        EVENT <= with_ev;
        @(posedge SYS_CLK);
        START <= 1'b0;
        EVENT <= 1'b0;
        exp_life = 22'({6'h00, init} << 6);
        exp_lo = 8'h00;
        exp_hi = 8'h00;
        #1 check("busy_after_start", {31'h0, BUSY}, 32'h0);
    endtask

    // reference arithmetic for one logging event
    task automatic model(input logic [9:0] m, output logic [7:0] idx);
        logic [9:0] d;
        logic [7:0] dec;
        d = m - tinit;
        idx = 8'(d >> 2);
        dec = 8'h00;
        if (d > 10'd236) begin
            exp_hi++;
            idx = 8'd59;
            exp_stat[2] = 1'b1;
        end
        if (tinit > m) begin
            exp_lo++;
            idx = 8'd0;
            exp_stat[1] = 1'b1;
        end
        for (int c = 0; c <= int'(idx); c++) begin
            dec = tab[c];
            exp_life = exp_life - {14'h0, dec};
        end
        if (idx != 8'd0 && idx < 8'd59) begin
            dec++;
            if (d[1]) exp_life = exp_life - {15'h0, dec[7:1]};
            if (d[0]) exp_life = exp_life - {16'h0, dec[7:2]};
        end
        exp_stat[0] = 1'b1;
        if (exp_life <= 0) exp_stat[3] = 1'b1;
    endtask

    // one event: busy length, then remaining life and error counters
    task automatic ev(input logic [9:0] m);
        int         n;
        logic [7:0] idx;
        model(m, idx);
        @(posedge SYS_CLK);
        EVENT <= 1'b1;
        MEAS <= m;
        @(posedge SYS_CLK);
        EVENT <= 1'b0;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            #1 n++;
        end while (BUSY === 1'b1 && n < 400);
        if (n >= 400) begin
            check("busy_timeout", 32'h1, 32'h0);
            results();
        end
        check("busy_cycles", 32'(n), 32'(idx) + 32'd2);
        rdc(life_pkg::LIFE_OFF, {10'h0, exp_life}, "life");
        check("life_frac", {10'h0, rd[21:0]}, {10'h0, exp_life});
        rdc(life_pkg::ERR_OFF, {16'h0, exp_hi, exp_lo}, "errors");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        exp_stat = 4'h0;
        meas_list = '{10'd100, 10'd107, 10'd110, 10'd333, 10'd336, 10'd337, 10'd99, 10'd101};
        repeat (5) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        rdc(life_pkg::CTRL_OFF, life_pkg::CTRL_RST, "ctrl_reset");
        rdc(life_pkg::STAT_OFF, 32'h0, "status_reset");
        rdc(life_pkg::ERR_OFF, 32'h0, "errors_reset");
        check("irq_reset", {31'h0, IRQ}, 32'h0);
        // entries alternate odd and even so truncation in the fraction matters
        for (int i = 0; i < 60; i++) begin
            tab[i] = 8'h21 + 8'(3 * i);
            wr(life_pkg::TABLE_OFF + 12'(4 * i), {24'h0, tab[i]});
        end
        rdc(life_pkg::TABLE_OFF + 12'h0ec, {24'h0, tab[59]}, "table_last");
        tinit = 10'h064;
        wr(life_pkg::TINIT_OFF, {22'h0, tinit});
        wr(life_pkg::INIT_OFF, 32'h0000_0400);
        wr(life_pkg::CTRL_OFF, 32'h0000_0001);
        start_log(16'h0400, 1'b1);
        rdc(life_pkg::LIFE_OFF, {10'h0, exp_life}, "life_seed");
        // zero, interpolation bits, index 58, top, beyond top, below initial
        foreach (meas_list[k]) ev(meas_list[k]);
        rdc(life_pkg::STAT_OFF, {28'h0, exp_stat}, "status_events");
        // interrupt: mask one event bit, clear by writing one
        wr(life_pkg::MASK_OFF, 32'h2);
        #1 check("irq_masked_in", {31'h0, IRQ}, 32'h1);
        wr(life_pkg::STAT_OFF, 32'h2);
        #1 check("irq_cleared", {31'h0, IRQ}, 32'h0);
        rdc(life_pkg::STAT_OFF, {28'h0, exp_stat & 4'hd}, "status_w1c");
        wr(life_pkg::STAT_OFF, 32'hf);
        // unmapped and read-only places
        apb(1'b0, 12'h01c, 32'h0);
        check("unmapped_err", {31'h0, er}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        wr(life_pkg::LIFE_OFF, 32'h0);
        rdc(life_pkg::LIFE_OFF, {10'h0, exp_life}, "life_read_only");
        // disabled: start seeds but events are ignored
        wr(life_pkg::CTRL_OFF, 32'h0);
        start_log(16'h0400, 1'b0);
        @(posedge SYS_CLK);
        EVENT <= 1'b1;
        MEAS <= 10'd200;
        @(posedge SYS_CLK);
        EVENT <= 1'b0;
        #1 check("busy_disabled", {31'h0, BUSY}, 32'h0);
        rdc(life_pkg::LIFE_OFF, {10'h0, exp_life}, "life_disabled");
        // expiry: small seed, counters cleared, then driven below zero
        wr(life_pkg::CTRL_OFF, 32'h3);
        wr(life_pkg::INIT_OFF, 32'h1);
        start_log(16'h0001, 1'b0);
        rdc(life_pkg::ERR_OFF, 32'h0, "errors_cleared");
        exp_stat = 4'h0;
        ev(10'd100);
        check("expired_positive", {31'h0, EXPIRED}, 32'h0);
        wr(life_pkg::MASK_OFF, 32'h8);
        ev(10'd336);
        rdc(life_pkg::STAT_OFF, {28'h0, exp_stat}, "status_expired_all");
        check("status_expired", {31'h0, rd[3]}, 32'h1);
        check("expired_pin", {31'h0, EXPIRED}, 32'h1);
        check("irq_expired", {31'h0, IRQ}, 32'h1);
        results();
    end
endmodule
